// ===== rtl/sep_pkg.sv
// Constants, opcodes and states of the serial EEPROM command port
package sep_pkg;
  // ===========================================================
  // Instruction encodings
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_PAGE = 2'h3;
  localparam logic [1:0] OP_MISC = 2'h0;
  localparam logic [1:0] SUB_FILL = 2'h1;
  localparam logic [1:0] SUB_SET = 2'h3;
  localparam logic [1:0] SUB_CLR = 2'h0;
  localparam logic [7:0] PROT_ALL_ONES = 8'hff;
  localparam logic [7:0] PROT_LOCK_ADDR = 8'h00;

  // ===========================================================
  // Clock counts from the start bit
  localparam logic [6:0] CNT_OPADDR = 7'h0b;
  localparam logic [6:0] CNT_ONE_WORD = 7'h1b;
  localparam logic [6:0] CNT_PAGE_MAX = 7'h4b;
  localparam logic [6:0] CNT_SAT = 7'h7f;
  localparam logic [3:0] WORD_END_LSB = 4'hb;
  localparam logic [4:0] OUT_LAST = 5'h0f;

  // ===========================================================
  // Reset values
  localparam logic [7:0] PROT_RST = 8'hff;
  localparam logic PROT_FLAG_RST = 1'b1;

  // ===========================================================
  // Timing at a 100 ns clock
  localparam int CLK_NS = 100;
  localparam int DESELECT_TO_SELECT_NS = 250;
  localparam int DESEL_CYC = (DESELECT_TO_SELECT_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_TIME_NS = 5000000;
  localparam int WRITE_CYC_DEF = WRITE_TIME_NS / CLK_NS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_READ = 2'b10,
    ST_PROG = 2'b11
  } sep_state_t;
endpackage

// ===== rtl/sep_port.sv
// Serial EEPROM command decoder, write sequencer and word FIFO
`timescale 1ns/10ps

// ===========================================================
// Word FIFO between the serial receiver and the programmer
module sep_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;

  // Extra pointer bit tells full from empty
  assign in_ready = (wr_ptr[PW] == rd_ptr[PW]) || (wr_ptr[PW-1:0] != rd_ptr[PW-1:0]);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data = store[rd_ptr[PW-1:0]];

  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      store[wr_ptr[PW-1:0]] <= in_data;
    end
  end

  // Clear drops a rejected command's words
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ===========================================================
// Command port top
module sep_port #(
  parameter int AW = 8,
  parameter int FIFO_DEPTH = 32,
  parameter int WRITE_CYC = sep_pkg::WRITE_CYC_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic sel,
  input wire logic sclk,
  input wire logic din,
  input wire logic write_enable_pin,
  input wire logic protect_enable_pin,
  output logic dout,
  output logic dout_oe_n,
  output logic busy,
  output logic write_latch
);
  localparam int EW = 25;
  sep_pkg::sep_state_t state;
  logic [4:0] pins_1;
  logic [4:0] pins_2;
  logic sclk_prev;
  logic sel_prev;
  logic [15:0] mem [0:2**AW-1];
  logic [6:0] cnt;
  logic [15:0] sr;
  logic [1:0] op;
  logic [7:0] addr;
  logic [7:0] cur;
  logic pre_c;
  logic aborted;
  logic [15:0] out_sr;
  logic [4:0] out_cnt;
  logic [7:0] prot_reg;
  logic prot_flag;
  logic otp;
  logic unlock;
  logic [31:0] timer;
  logic [7:0] desel_cnt;
  logic ready_show;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [EW-1:0] fifo_out;
  logic fifo_clear;

  // ===========================================================
  // Pin synchronisers, two flops per input
  logic [4:0] pins;
  assign pins = {protect_enable_pin, write_enable_pin, din, sclk, sel};
  for (genvar i = 0; i < 5; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (rst) begin
        pins_1[i] <= 1'b0;
        pins_2[i] <= 1'b0;
      end else begin
        pins_1[i] <= pins[i];
        pins_2[i] <= pins_1[i];
      end
    end
  end

  logic sel_s, sclk_s, din_s, wen_s, pre_s;
  assign {pre_s, wen_s, din_s, sclk_s, sel_s} = pins_2;

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_prev <= 1'b0;
      sel_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
      sel_prev <= sel_s;
    end
  end

  // ===========================================================
  // Decode helpers
  logic rise, sel_fall;
  logic [6:0] next_cnt;
  logic [15:0] next_sr;
  logic is_fill, is_wtype, word_done, push, prot_hit;
  logic [7:0] mask;
  logic [7:0] next_rd;
  logic cnt_ok, start_prog;
  assign rise = sclk_s && !sclk_prev;
  assign sel_fall = sel_prev && !sel_s;
  assign next_cnt = (cnt == sep_pkg::CNT_SAT) ? cnt : cnt + 7'h01;
  assign next_sr = {sr[14:0], din_s};
  assign mask = 8'((1 << AW) - 1);
  assign next_rd = (addr + 8'h01) & mask;
  assign is_fill = (op == sep_pkg::OP_MISC) && (addr[7:6] == sep_pkg::SUB_FILL);
  assign is_wtype = !pre_c && (op == sep_pkg::OP_WRITE || op == sep_pkg::OP_PAGE || is_fill);
  assign word_done = next_cnt >= sep_pkg::CNT_ONE_WORD && next_cnt[3:0] == sep_pkg::WORD_END_LSB;
  // One word for write and fill, up to four for a page
  // A select fall that starts no programming flushes the FIFO, so a rise seen with any select fall must not push
  assign push = state == sep_pkg::ST_SHIFT && rise && !sel_fall && is_wtype && word_done
    && (op == sep_pkg::OP_PAGE ? next_cnt <= sep_pkg::CNT_PAGE_MAX
        : next_cnt == sep_pkg::CNT_ONE_WORD);
  assign prot_hit = !prot_flag && ((cur & mask) >= prot_reg);
  // Exact clock count checked at the select fall
  always_comb begin
    cnt_ok = 1'b0;
    if (op == sep_pkg::OP_PAGE) begin
      cnt_ok = cnt >= sep_pkg::CNT_ONE_WORD && cnt <= sep_pkg::CNT_PAGE_MAX
        && cnt[3:0] == sep_pkg::WORD_END_LSB;
    end else begin
      cnt_ok = cnt == sep_pkg::CNT_ONE_WORD;
    end
  end
  assign start_prog = state == sep_pkg::ST_SHIFT && sel_fall && is_wtype && cnt_ok
    && write_latch && wen_s && !aborted && (!is_fill || prot_flag);
  assign fifo_clear = state == sep_pkg::ST_SHIFT && sel_fall && !start_prog;

  // ===========================================================
  // Serial command state machine
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= sep_pkg::ST_IDLE;
      cnt <= '0;
      sr <= '0;
      op <= '0;
      addr <= '0;
      cur <= '0;
      pre_c <= 1'b0;
      aborted <= 1'b0;
      out_sr <= '0;
      out_cnt <= '0;
    end else begin
      unique case (state)
        sep_pkg::ST_IDLE: begin
          // Leading zeros are skipped until the first one
          if (sel_s && rise && din_s) begin
            state <= sep_pkg::ST_SHIFT;
            cnt <= 7'h01;
            sr <= '0;
            op <= sep_pkg::OP_READ;
            pre_c <= pre_s;
            aborted <= 1'b0;
          end
        end
        sep_pkg::ST_SHIFT: begin
          if (sel_fall) begin
            state <= start_prog ? sep_pkg::ST_PROG : sep_pkg::ST_IDLE;
          end else if (rise) begin
            cnt <= next_cnt;
            sr <= next_sr;
            if (next_cnt == sep_pkg::CNT_OPADDR) begin
              op <= next_sr[9:8];
              addr <= next_sr[7:0] & mask;
              cur <= next_sr[7:0];
              pre_c <= pre_s;
              if (next_sr[9:8] == sep_pkg::OP_READ) begin
                state <= sep_pkg::ST_READ;
                out_cnt <= '0;
                if (pre_s) begin
                  out_sr <= {prot_reg, prot_flag, 7'h00};
                end else begin
                  out_sr <= mem[next_sr[7:0] & mask];
                end
              end
            end
            if (push) begin
              cur <= {cur[7:2], cur[1:0] + 2'h1};
              aborted <= aborted || prot_hit || !fifo_in_ready;
            end
          end
        end
        sep_pkg::ST_READ: begin
          if (!sel_s) begin
            state <= sep_pkg::ST_IDLE;
          end else if (rise) begin
            out_sr <= {out_sr[14:0], 1'b0};
            out_cnt <= out_cnt + 5'h01;
            if (out_cnt == sep_pkg::OUT_LAST && !pre_c) begin
              addr <= next_rd;
              out_sr <= mem[next_rd];
              out_cnt <= '0;
            end
          end
        end
        sep_pkg::ST_PROG: begin
          // Serial pins are not looked at here
          if (timer == '0 && !fifo_out_valid) begin
            state <= sep_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ===========================================================
  // Write latch and protection register, applied at select fall
  logic misc_done;
  assign misc_done = state == sep_pkg::ST_SHIFT && sel_fall && cnt == sep_pkg::CNT_OPADDR;
  always_ff @(posedge clock) begin
    if (rst) begin
      write_latch <= 1'b0;
      prot_reg <= sep_pkg::PROT_RST;
      prot_flag <= sep_pkg::PROT_FLAG_RST;
      otp <= 1'b0;
      unlock <= 1'b0;
    end else if (state == sep_pkg::ST_SHIFT && sel_fall) begin
      // Unlock only lasts until the next command that is not a read
      unlock <= misc_done && pre_c && wen_s && write_latch && op == sep_pkg::OP_MISC
        && addr[7:6] == sep_pkg::SUB_SET;
      if (misc_done && !pre_c && op == sep_pkg::OP_MISC) begin
        if (addr[7:6] == sep_pkg::SUB_SET && wen_s) begin
          write_latch <= 1'b1;
        end else if (addr[7:6] == sep_pkg::SUB_CLR) begin
          write_latch <= 1'b0;
        end
      end
      if (misc_done && pre_c && wen_s && write_latch && unlock && !otp) begin
        if (op == sep_pkg::OP_WRITE) begin
          prot_reg <= addr;
          prot_flag <= 1'b0;
        end else if (op == sep_pkg::OP_PAGE && addr == sep_pkg::PROT_ALL_ONES) begin
          prot_reg <= sep_pkg::PROT_ALL_ONES;
          prot_flag <= 1'b1;
        end else if (op == sep_pkg::OP_MISC && addr == sep_pkg::PROT_LOCK_ADDR) begin
          otp <= 1'b1;
        end
      end
    end
  end

  // ===========================================================
  // Self-timed programming: FIFO drains while the timer runs
  logic pop;
  assign pop = state == sep_pkg::ST_PROG && fifo_out_valid;
  assign busy = state == sep_pkg::ST_PROG;
  always_ff @(posedge clock) begin
    if (rst) begin
      timer <= '0;
      desel_cnt <= '0;
    end else if (start_prog) begin
      timer <= 32'(WRITE_CYC);
      desel_cnt <= '0;
    end else if (state == sep_pkg::ST_PROG) begin
      if (timer != '0) begin
        timer <= timer - 32'h1;
      end
      if (!sel_s && desel_cnt < 8'(sep_pkg::DESEL_CYC)) begin
        desel_cnt <= desel_cnt + 8'h01;
      end
    end
  end

  // Fill-all writes every word in the same cycle
  always_ff @(posedge clock) begin
    if (pop) begin
      for (int j = 0; j < 2**AW; j++) begin
        if (fifo_out[24] || fifo_out[23:16] == 8'(j)) begin
          mem[j] <= fifo_out[15:0];
        end
      end
    end
  end

  sep_fifo #(.WIDTH(EW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .clear(fifo_clear),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({is_fill, cur & mask, next_sr}),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out)
  );

  // ===========================================================
  // Data out: read stream, busy and ready status
  always_ff @(posedge clock) begin
    if (rst) begin
      ready_show <= 1'b0;
    end else if (state == sep_pkg::ST_PROG && timer == '0 && !fifo_out_valid) begin
      ready_show <= 1'b1;
    end else if (!sel_s || (rise && din_s)) begin
      ready_show <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dout <= 1'b1;
      dout_oe_n <= 1'b1;
    end else if (state == sep_pkg::ST_PROG) begin
      dout <= 1'b0;
      dout_oe_n <= !(sel_s && desel_cnt >= 8'(sep_pkg::DESEL_CYC));
    end else if (ready_show && sel_s) begin
      dout <= 1'b1;
      dout_oe_n <= 1'b0;
    end else if (state == sep_pkg::ST_SHIFT && rise && next_cnt == sep_pkg::CNT_OPADDR
        && next_sr[9:8] == sep_pkg::OP_READ) begin
      dout <= 1'b0;
      dout_oe_n <= 1'b0;
    end else if (state == sep_pkg::ST_READ && sel_s) begin
      dout_oe_n <= 1'b0;
      if (rise) begin
        dout <= out_sr[15];
      end
    end else begin
      dout_oe_n <= 1'b1;
    end
  end

  // ===========================================================
  // Assertions and covers
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_latch_reset: assert property ($past(rst) |-> !write_latch)
    else $error("write latch not clear after reset");
  a_clear_latch: assert property (misc_done && !pre_c && op == sep_pkg::OP_MISC
    && addr[7:6] == sep_pkg::SUB_CLR |=> !write_latch)
    else $error("clear command left latch set");
  a_no_latch_prog: assert property (state == sep_pkg::ST_SHIFT && sel_fall && !write_latch
    |=> state != sep_pkg::ST_PROG)
    else $error("programming without write latch");
  a_bad_count: assert property (state == sep_pkg::ST_SHIFT && sel_fall && !cnt_ok
    |=> state == sep_pkg::ST_IDLE)
    else $error("wrong count started programming");
  a_busy_ignore: assert property (state == sep_pkg::ST_PROG
    |=> state == sep_pkg::ST_PROG || state == sep_pkg::ST_IDLE)
    else $error("left programming early");
  a_busy_low: assert property (state == sep_pkg::ST_PROG && $past(state) == sep_pkg::ST_PROG
    && !dout_oe_n |-> !dout)
    else $error("busy status not low");
  a_dummy_zero: assert property (state == sep_pkg::ST_SHIFT && rise
    && next_cnt == sep_pkg::CNT_OPADDR && next_sr[9:8] == sep_pkg::OP_READ
    && !(ready_show && sel_s) |=> !dout && !dout_oe_n)
    else $error("no dummy zero before read data");
  a_page_wrap: assert property (push |=> cur[7:2] == $past(cur[7:2])
    && cur[1:0] == $past(cur[1:0]) + 2'h1)
    else $error("page address left the page");
  a_stream_next: assert property (state == sep_pkg::ST_READ && sel_s && rise && !pre_c
    && out_cnt == sep_pkg::OUT_LAST |=> addr == (($past(addr) + 8'h01) & mask))
    else $error("read address did not advance");
  a_sample_bit: assert property (state == sep_pkg::ST_SHIFT && sel_s && rise
    |=> sr[0] == $past(din_s))
    else $error("data bit not sampled");

  c_stream: cover property (state == sep_pkg::ST_READ && out_cnt == sep_pkg::OUT_LAST && rise);
  c_page: cover property (start_prog && op == sep_pkg::OP_PAGE && cnt == sep_pkg::CNT_PAGE_MAX);
  c_fill: cover property (pop && fifo_out[24]);
  c_abort: cover property (fifo_clear && is_wtype);
endmodule

// ===== verif/sep_master.sv
// Bus master model that drives the serial select, clock and data lines
`timescale 1ns/10ps
module sep_master (
  input wire logic clock,
  input wire logic dout,
  output logic sel,
  output logic sclk,
  output logic din
);
  // ==========================================
  // Idle lines: the serial clock stands low between frames
  initial begin
    sel = 1'b0;
    sclk = 1'b0;
    din = 1'b0;
  end

  // ==========================================
  // One frame of n bits, MSB first
  // Six clocks per half period covers the pin synchronisers; dout is taken late in the high phase
  task automatic shift(input logic [79:0] bits, input int n, output logic [79:0] got);
    got = '0;
    @(negedge clock);
    sel = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      din = bits[i];
      repeat (6) @(negedge clock);
      sclk = ~sclk;
      repeat (6) @(negedge clock);
      got[i] = dout;
      sclk = ~sclk;
    end
  endtask

  // Select drops right after the last fall; released data shows the inverse level
  task automatic deselect(input int n);
    sel = 1'b0;
    din = ~din;
    repeat (n) @(negedge clock);
  endtask

  // Select raised with the clock held still, to watch the status on dout
  task automatic poll();
    sel = 1'b1;
    repeat (6) @(negedge clock);
  endtask
endmodule

// ===== verif/testbench.sv
// Self-checking bench for the serial EEPROM command port
`timescale 1ns/10ps
module testbench;
  localparam int WCYC = 400;
  localparam int LIMIT = 60000;
  logic clock, rst, sel, sclk, din, write_enable_pin, protect_enable_pin;
  logic dout, dout_oe_n, busy, write_latch;
  logic [79:0] got;
  logic [63:0] pw;
  logic [31:0] seed = 32'h00000b44;
  logic [7:0] a, b;
  logic [15:0] d;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int pbound, pflag;
  int mem[256];

  // Write time shortened so that one whole frame still fits inside it
  sep_port #(.WRITE_CYC(WCYC)) u_dut (
    .clock(clock), .rst(rst), .sel(sel), .sclk(sclk), .din(din),
    .write_enable_pin(write_enable_pin), .protect_enable_pin(protect_enable_pin),
    .dout(dout), .dout_oe_n(dout_oe_n), .busy(busy), .write_latch(write_latch));

  sep_master u_master (.clock(clock), .dout(dout), .sel(sel), .sclk(sclk), .din(din));

  // ==========================================
  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_mismatch++;
      $display("FAIL %0t run exceeded its cycle budget", $time);
      stop_test();
    end
  end

  // ==========================================
  // Helpers
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction

  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, msg);
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished, %0d mismatches so far", s, n_mismatch);
  endtask

  task automatic stop_test();
    $display("mismatches %0d, checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmd(input logic [79:0] bits, input int n);
    u_master.shift(bits, n, got);
    u_master.deselect(6);
  endtask

  task automatic idle();
    for (int k = 0; k < 1000 && busy !== 1'b0; k++) @(negedge clock);
    chk(busy === 1'b0, "programming never ended");
  endtask

  // Write-type frame, then status poll; ok tells whether programming must start
  task automatic prog(input logic [79:0] bits, input int n, input bit ok);
    u_master.shift(bits, n, got);
    u_master.deselect(8);
    u_master.poll();
    chk(busy === ok && (!ok || (dout === 1'b0 && dout_oe_n === 1'b0)), "busy status");
    idle();
    // Ready reaches dout one clock after busy drops
    repeat (2) @(negedge clock);
    if (ok) chk(dout === 1'b1, "ready status");
    u_master.deselect(6);
  endtask

  // Read nw words and compare each with the model
  task automatic rd(input logic [7:0] ad, input int nw);
    logic [15:0] w;
    logic [15:0] r;
    // Write enable is a don't-care for reads, so it is left random here
    r = rnd();
    write_enable_pin = r[0];
    u_master.shift(80'({3'b110, ad, 64'h0}) >> (16 * (4 - nw)), 11 + 16 * nw, got);
    chk(got[16 * nw] === 1'b0 && dout_oe_n === 1'b0, "dummy bit");
    for (int k = 0; k < nw; k++) begin
      w = got[16 * (nw - k) - 1 -: 16];
      chk(w === 16'(mem[(ad + k) % 256]), "read word");
    end
    u_master.deselect(6);
    write_enable_pin = 1'b1;
  endtask

  task automatic prd();
    logic [15:0] r;
    r = rnd();
    write_enable_pin = r[0];
    u_master.shift(80'({3'b110, 18'h0}), 21, got);
    chk(got[10:1] === {1'b0, 8'(pbound), 1'(pflag)}, "protection read");
    u_master.deselect(6);
    write_enable_pin = 1'b1;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    rst = 1'b1;
    write_enable_pin = 1'b1;
    protect_enable_pin = 1'b0;
    pbound = 255;
    pflag = 1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (3) @(negedge clock);
    chk(write_latch === 1'b0 && busy === 1'b0 && dout === 1'b1 && dout_oe_n === 1'b1, "reset");
    d = rnd();
    prog(80'({5'b10001, 6'h0, d}), 27, 0);
    write_enable_pin = 1'b0;
    cmd(80'({5'b10011, 6'h0}), 11);
    chk(write_latch === 1'b0, "latch set with pin low");
    write_enable_pin = 1'b1;
    cmd(80'({5'b10011, 6'h2a}), 11);
    chk(write_latch === 1'b1, "latch set");
    prog(80'({5'b10001, 6'h15, d}), 27, 1);
    for (int k = 0; k < 256; k++) mem[k] = d;
    rd(8'hff, 2);
    done("fill and stream");
    // Single write, then two miscounted writes that must change nothing
    a = 8'(rnd());
    d = rnd();
    prog(80'({3'b101, a, d}), 27, 1);
    mem[a] = d;
    prog(80'({3'b101, a, ~d, 1'b0}), 28, 0);
    prog(80'({3'b101, a, 15'h0}), 26, 0);
    rd(a, 1);
    // Page starting mid-page wraps in the low two address bits
    a = {a[7:2], 2'b10};
    pw = {rnd(), rnd(), rnd(), rnd()};
    prog(80'({3'b111, a, pw}), 75, 1);
    for (int k = 0; k < 4; k++) mem[{a[7:2], 2'(a[1:0] + k)}] = pw[63 - 16 * k -: 16];
    rd({a[7:2], 2'b00}, 4);
    done("write and page");
    // A frame sent during programming is ignored and the timer runs on
    b = {a[7:1], 1'b0};
    d = rnd();
    u_master.shift(80'({3'b101, b, d}), 27, got);
    u_master.deselect(8);
    u_master.shift(80'({3'b101, b + 8'h01, ~d}), 27, got);
    chk(busy === 1'b1, "busy through ignored frame");
    u_master.deselect(6);
    idle();
    mem[b] = d;
    rd(b, 2);
    done("busy ignore");
    // Protection boundary and its effect on writes
    b = {1'b1, 5'(rnd()), 2'b10};
    protect_enable_pin = 1'b1;
    cmd(80'({5'b10011, 6'h0}), 11);
    cmd(80'({3'b101, b}), 11);
    pbound = b;
    pflag = 0;
    prd();
    protect_enable_pin = 1'b0;
    d = rnd();
    prog(80'({3'b101, b, d}), 27, 0);
    prog(80'({3'b101, b - 8'h01, d}), 27, 1);
    mem[b - 8'h01] = d;
    prog(80'({3'b111, b - 8'h02, pw}), 75, 0);
    prog(80'({5'b10001, 6'h0, d}), 27, 0);
    rd(b - 8'h02, 4);
    // Clear, then lock; a later boundary write must not take effect
    protect_enable_pin = 1'b1;
    cmd(80'({5'b10011, 6'h0}), 11);
    cmd(80'({3'b111, 8'hff}), 11);
    pbound = 255;
    pflag = 1;
    prd();
    cmd(80'({5'b10011, 6'h0}), 11);
    cmd(80'({3'b100, 8'h00}), 11);
    cmd(80'({5'b10011, 6'h0}), 11);
    cmd(80'({3'b101, b}), 11);
    prd();
    done("protection");
    // Latch cleared: writes refused, reads still served
    protect_enable_pin = 1'b0;
    cmd(80'({3'b100, 8'h00}), 11);
    chk(write_latch === 1'b0, "latch clear");
    prog(80'({3'b101, a, ~d}), 27, 0);
    rd(a, 1);
    done("latch clear");
    stop_test();
  end
endmodule
